// ### rcs_cadence_sequencer.sv
// Ringing cadence sequencer: Avalon-MM register slave, script engine, off-hook handling.
// Assumes one 250 MHz clock, a synchronous active-low reset and an asynchronous hook pin.
`timescale 1ns/10ps
`include "rcs_consts.svh"

// Summary of operation
// - Four fixed cadences: continuous, single burst, single ring, double ring.
// - Single ring cadence: ringing on 2 s, then off 4 s, repeated.
// - Double ring: on 700 ms, off 600, on 700, off 4000, repeated.
// - Endless cadence runs until a manual stop or an off-hook stop.
// - First statement of a script is its name, never executed.
// - Each generator setting can be assigned, incremented or decremented.
// - Assignment sets the frequency directly; increment adds operand to it.
// - Loop with a count runs its body exactly that many times.
// - Loop without an operand repeats its body forever.
// - Loops nest up to ten deep, each with its own count.
// - Numeric statement waits that many milliseconds, 1 to 1,000,000.
// - On starts ringing, off stops it, in script order with delays.
// - Script ends after its last statement or at a stop statement.
// - Ending a script leaves the ringing state untouched.
// - Ringing left on stays on until an off-hook stop or a manual stop.
// - Mute action zeroes AC level while off-hook; script keeps running.
// - Stop action (default) shuts ringing down; no restart at on-hook.
module rcs_cadence_sequencer
#(
	parameter int TICK_CYCLES = `RCS_TICK_CYCLES,
	parameter int LOOP_DEPTH = 10,
	parameter int USER_WORDS = 64
)
(
	input wire logic core_clk, // Core clock, 250 MHz
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic [5:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall the master
	input wire logic offhook_pin, // Line off-hook, asynchronous
	output logic ring_on, // AC ringing enable to the generator
	output logic ac_mute, // Force AC level to zero
	output logic cadence_active, // Script is running
	output logic [15:0] ring_freq, // Frequency setting
	output logic [15:0] ring_level, // AC level setting
	output logic [15:0] ring_offset, // DC offset setting
	output rcs_pkg::rcs_hook_act_t hook_action // Off-hook action in force
);
	import rcs_pkg::*;
	localparam int PCW = $clog2(USER_WORDS) + 1;
	localparam int DW = $clog2(LOOP_DEPTH + 1);

	typedef struct packed {
		logic [PCW-1:0] start;
		logic [19:0] count;
	} rcs_frame_t;

	typedef struct packed {
		rcs_seq_state_t fsm;
		logic [PCW-1:0] pc;
		logic [19:0] delay;
		logic [DW-1:0] depth;
		rcs_frame_t [LOOP_DEPTH-1:0] stack;
		logic [3:0][15:0] setting;
		logic ring;
		logic mute;
		logic active;
		logic nest_err;
		logic [2:0] sel;
		logic [2:0] run_sel;
		rcs_hook_act_t act;
		logic [PCW-1:0] paddr;
		logic [2:0] sync;
		logic hook;
		logic waitreq;
		logic [31:0] rdata;
	} rcs_state_t;

	rcs_state_t st_q;
	rcs_state_t st_d;
	rcs_instr_t instr;
	rcs_frame_t top;
	logic [DW-1:0] dm1;
	logic tick;
	logic restart;
	logic ram_we;
	logic start_req;
	logic stop_req;
	logic halt_hook;
	logic run_ok;
	logic [15:0] cur_set;

	if (LOOP_DEPTH < 1 || LOOP_DEPTH > 15 || USER_WORDS < 16 || TICK_CYCLES < 2)
		$error("rcs_cadence_sequencer parameters out of range");

	function automatic logic [1:0] set_index(logic [5:0] a);
		set_index = a[3:2];
	endfunction

	function automatic logic [31:0] read_word(rcs_state_t s, logic [5:0] a);
		read_word = 32'h00000000;
		case (a)
		`RCS_OFF_CTRL:
		begin
			read_word[`RCS_CTRL_SEL_LO +: 3] = s.sel;
			read_word[`RCS_CTRL_ACT_LO +: 2] = s.act;
		end
		`RCS_OFF_STATUS:
		begin
			read_word[`RCS_ST_RUN] = s.active;
			read_word[`RCS_ST_RING] = s.ring;
			read_word[`RCS_ST_MUTE] = s.mute;
			read_word[`RCS_ST_HOOK] = s.hook;
			read_word[`RCS_ST_ERR] = s.nest_err;
			read_word[`RCS_ST_DEPTH_LO +: DW] = s.depth;
		end
		`RCS_OFF_PADDR: read_word[PCW-1:0] = s.paddr;
		`RCS_OFF_FREQ, `RCS_OFF_LEVEL, `RCS_OFF_OFFSET, `RCS_OFF_SHAPE:
			read_word[15:0] = s.setting[set_index(a)];
		default: ;
		endcase
	endfunction

	rcs_ms_tick
	#(
		.CYCLES(TICK_CYCLES)
	)
	u_tick
	(
		.core_clk(core_clk),
		.reset_n(reset_n),
		.restart(restart),
		.tick(tick)
	);

	rcs_script_store
	#(
		.USER_WORDS(USER_WORDS),
		.PCW(PCW)
	)
	u_store
	(
		.core_clk(core_clk),
		.wr_en(ram_we),
		.wr_addr(st_q.paddr),
		.wr_data(avs_writedata),
		.sel(st_q.run_sel),
		.pc(st_q.pc),
		.instr(instr)
	);

	assign dm1 = st_q.depth - 1'h1;
	assign top = st_q.stack[dm1];
	assign cur_set = st_q.setting[instr.idx];
	assign halt_hook = st_q.hook && (st_q.act == RCS_HOOK_STOP);

	always_comb
	begin
		st_d = st_q;
		restart = 1'h0;
		ram_we = 1'h0;
		start_req = 1'h0;
		stop_req = 1'h0;
		// Hook pin: the change counts once the second and third stages agree
		st_d.sync = {st_q.sync[1:0], offhook_pin};
		if (st_q.sync[1] == st_q.sync[2])
			st_d.hook = st_q.sync[2];
		// One wait cycle per access, then the answer stands for one cycle
		if (st_q.waitreq && (avs_read || avs_write))
		begin
			st_d.waitreq = 1'h0;
			st_d.rdata = read_word(st_q, avs_address);
		end
		else
			st_d.waitreq = 1'h1;
		if (avs_write && !st_q.waitreq)
		begin
			case (avs_address)
			`RCS_OFF_CTRL:
			begin
				st_d.sel = avs_writedata[`RCS_CTRL_SEL_LO +: 3];
				st_d.act = rcs_hook_act_t'(avs_writedata[`RCS_CTRL_ACT_LO +: 2]);
				start_req = avs_writedata[`RCS_CTRL_START];
				stop_req = avs_writedata[`RCS_CTRL_STOP];
			end
			`RCS_OFF_PADDR: st_d.paddr = avs_writedata[PCW-1:0];
			`RCS_OFF_PDATA:
			begin
				ram_we = 1'h1;
				st_d.paddr = st_q.paddr + 1'h1;
			end
			`RCS_OFF_FREQ, `RCS_OFF_LEVEL, `RCS_OFF_OFFSET, `RCS_OFF_SHAPE:
				st_d.setting[set_index(avs_address)] = avs_writedata[15:0];
			default: ;
			endcase
		end
		case (st_q.fsm)
		RCS_RUN:
		begin
			st_d.pc = st_q.pc + 1'h1;
			case (instr.op)
			RCS_OP_NAME: ;
			RCS_OP_ON: st_d.ring = 1'h1;
			RCS_OP_OFF: st_d.ring = 1'h0;
			RCS_OP_DELAY:
			begin
				if (instr.arg == 20'h00000)
					st_d.delay = 20'h00001;
				else if (instr.arg > `RCS_DELAY_MAX_MS)
					st_d.delay = `RCS_DELAY_MAX_MS;
				else
					st_d.delay = instr.arg;
				st_d.fsm = RCS_WAIT;
				restart = 1'h1;
			end
			RCS_OP_LOOP_OPEN:
			begin
				if (st_q.depth == DW'(LOOP_DEPTH))
				begin
					st_d.nest_err = 1'h1;
					st_d.fsm = RCS_IDLE;
				end
				else
				begin
					st_d.stack[st_q.depth] = '{start: st_q.pc + 1'h1, count: instr.arg};
					st_d.depth = st_q.depth + 1'h1;
				end
			end
			RCS_OP_REPEAT_CLOSE:
			begin
				if (st_q.depth == '0)
				begin
					st_d.nest_err = 1'h1;
					st_d.fsm = RCS_IDLE;
				end
				else if (top.count == 20'h00000)
					st_d.pc = top.start;
				else if (top.count != 20'h00001)
				begin
					st_d.stack[dm1].count = top.count - 1'h1;
					st_d.pc = top.start;
				end
				else
					st_d.depth = dm1;
			end
			RCS_OP_STOP: st_d.fsm = RCS_IDLE;
			RCS_OP_SET: st_d.setting[instr.idx] = instr.arg[15:0];
			RCS_OP_INC: st_d.setting[instr.idx] = cur_set + instr.arg[15:0];
			RCS_OP_DEC: st_d.setting[instr.idx] = cur_set - instr.arg[15:0];
			default: st_d.fsm = RCS_IDLE;
			endcase
		end
		RCS_WAIT:
		begin
			if (tick)
			begin
				st_d.delay = st_q.delay - 1'h1;
				if (st_q.delay == 20'h00001)
					st_d.fsm = RCS_RUN;
			end
		end
		default: ;
		endcase
		if (start_req && !halt_hook)
		begin
			st_d.fsm = RCS_RUN;
			st_d.pc = PCW'(1);
			st_d.depth = '0;
			// A nesting fault raised in this same cycle outlives the restart
			st_d.nest_err = st_d.nest_err && !st_q.nest_err;
			st_d.run_sel = st_d.sel;
		end
		// Manual or off-hook stop beats a start and any script step
		if (stop_req || halt_hook)
		begin
			st_d.fsm = RCS_IDLE;
			st_d.ring = 1'h0;
		end
		st_d.mute = st_q.hook && (st_q.act == RCS_HOOK_MUTE);
		st_d.active = st_d.fsm != RCS_IDLE;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			st_q <= '0;
			st_q.fsm <= RCS_IDLE;
			st_q.act <= RCS_HOOK_STOP;
			st_q.waitreq <= 1'h1;
			st_q.setting <= {`RCS_RST_SHAPE, `RCS_RST_OFFSET, `RCS_RST_LEVEL, `RCS_RST_FREQ};
		end
		else
			st_q <= st_d;
	end

	assign avs_readdata = st_q.rdata;
	assign avs_waitrequest = st_q.waitreq;
	assign ring_on = st_q.ring;
	assign ac_mute = st_q.mute;
	assign cadence_active = st_q.active;
	assign ring_freq = st_q.setting[0];
	assign ring_level = st_q.setting[1];
	assign ring_offset = st_q.setting[2];
	assign hook_action = st_q.act;

	assign run_ok = (st_q.fsm == RCS_RUN) && !start_req && !stop_req && !halt_hook;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_exec(rcs_op_t o);
		run_ok && (instr.op == o);
	endsequence

	sequence s_bus_answer;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	a_name_skipped: assert property (start_req && !stop_req && !halt_hook
		|=> st_q.pc == PCW'(1) && cadence_active)
		else $error("script did not start after its name");
	a_on_rings: assert property (s_exec(RCS_OP_ON) |=> ring_on)
		else $error("on statement did not enable ringing");
	a_off_silences: assert property (s_exec(RCS_OP_OFF) |=> !ring_on)
		else $error("off statement did not stop ringing");
	a_delay_waits: assert property (s_exec(RCS_OP_DELAY)
		|=> st_q.fsm == RCS_WAIT && st_q.delay != 20'h00000 && st_q.pc == $past(st_q.pc) + 1'h1)
		else $error("delay statement did not wait");
	a_wait_holds_pc: assert property (st_q.fsm == RCS_WAIT && !tick && !start_req
		&& !stop_req && !halt_hook
		|=> st_q.pc == $past(st_q.pc) && ring_on == $past(ring_on))
		else $error("state moved during a delay");
	a_set_value: assert property (s_exec(RCS_OP_SET) && instr.idx == 2'h0
		|=> ring_freq == $past(instr.arg[15:0]))
		else $error("frequency assignment wrong");
	a_inc_adds: assert property (s_exec(RCS_OP_INC) && instr.idx == 2'h0
		|=> ring_freq == 16'($past(cur_set) + $past(instr.arg[15:0])))
		else $error("frequency increment wrong");
	a_dec_subs: assert property (s_exec(RCS_OP_DEC) && instr.idx == 2'h1
		|=> ring_level == 16'($past(cur_set) - $past(instr.arg[15:0])))
		else $error("level decrement wrong");
	a_loop_push: assert property (s_exec(RCS_OP_LOOP_OPEN) && st_q.depth < DW'(LOOP_DEPTH)
		|=> st_q.depth == $past(st_q.depth) + 1'h1)
		else $error("loop open did not nest");
	a_loop_repeat: assert property (s_exec(RCS_OP_REPEAT_CLOSE) && st_q.depth != '0
		&& top.count != 20'h00001 |=> st_q.pc == $past(top.start))
		else $error("loop did not repeat");
	a_loop_exit: assert property (s_exec(RCS_OP_REPEAT_CLOSE) && st_q.depth != '0
		&& top.count == 20'h00001 |=> st_q.depth == $past(dm1) && st_q.pc == $past(st_q.pc) + 1'h1)
		else $error("loop did not exit after its count");
	a_end_keeps: assert property (s_exec(RCS_OP_END)
		|=> !cadence_active && ring_on == $past(ring_on))
		else $error("script end changed ringing");
	a_stop_ends: assert property (s_exec(RCS_OP_STOP) |=> !cadence_active)
		else $error("stop statement did not end script");
	a_hook_stop: assert property (halt_hook |=> !ring_on && !cadence_active)
		else $error("off-hook stop not applied");
	a_hook_mute: assert property (st_q.hook && st_q.act == RCS_HOOK_MUTE
		&& !stop_req |=> ac_mute && (cadence_active || $past(st_q.fsm) != RCS_WAIT))
		else $error("off-hook mute not applied");
	a_unmute: assert property (!st_q.hook |=> !ac_mute)
		else $error("mute not released on-hook");
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> s_bus_answer)
		else $error("bus answer timing wrong");
endmodule

// ### rcs_consts.svh
// Constants of the ringing cadence sequencer: register offsets, fields, resets, timing.
// Assumes byte addresses on a 32-bit Avalon-MM bus and a 4 ns core clock.
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH
`define RCS_OFF_CTRL 6'h00
`define RCS_OFF_STATUS 6'h04
`define RCS_OFF_PADDR 6'h08
`define RCS_OFF_PDATA 6'h0C
`define RCS_OFF_FREQ 6'h10
`define RCS_OFF_LEVEL 6'h14
`define RCS_OFF_OFFSET 6'h18
`define RCS_OFF_SHAPE 6'h1C
`define RCS_CTRL_START 0
`define RCS_CTRL_STOP 1
`define RCS_CTRL_SEL_LO 2
`define RCS_CTRL_ACT_LO 5
`define RCS_ST_RUN 0
`define RCS_ST_RING 1
`define RCS_ST_MUTE 2
`define RCS_ST_HOOK 3
`define RCS_ST_ERR 4
`define RCS_ST_DEPTH_LO 8
`define RCS_RST_FREQ 16'h0016
`define RCS_RST_LEVEL 16'h0000
`define RCS_RST_OFFSET 16'h0000
`define RCS_RST_SHAPE 16'h0000
`define RCS_CLK_PERIOD_NS 4
`define RCS_TICK_PERIOD_NS 1000000
`define RCS_TICK_CYCLES (`RCS_TICK_PERIOD_NS / `RCS_CLK_PERIOD_NS)
`define RCS_DELAY_MAX_MS 20'hF4240
`define RCS_BURST_MS 20'h007D0
`define RCS_SINGLE_ON_MS 20'h007D0
`define RCS_SINGLE_OFF_MS 20'h00FA0
`define RCS_DOUBLE_ON_MS 20'h002BC
`define RCS_DOUBLE_GAP_MS 20'h00258
`define RCS_DOUBLE_OFF_MS 20'h00FA0
`endif

// ### rcs_host_model.sv
// Host side of the register bus: Avalon-MM master tasks and script loading.
// Assumes callers enter a task right after a rising edge of the core clock.
`timescale 1ns/10ps
module rcs_host_model
(
	input wire logic core_clk, // Core clock
	output logic [5:0] avs_address, // Byte address
	output logic avs_read, // Read request
	output logic avs_write, // Write request
	output logic [31:0] avs_writedata, // Write data
	input wire logic [31:0] avs_readdata, // Read data
	input wire logic avs_waitrequest // Slave stall
);
	initial
	begin
		avs_address = 6'h00;
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_writedata = 32'h00000000;
	end

	// Request held until waitrequest is seen low at a rising edge
	task automatic xfer(input logic rd, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= rd;
		avs_write <= !rd;
		do
			@(posedge core_clk);
		while (avs_waitrequest !== 1'h0);
		q = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		@(posedge core_clk);
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'h0, a, d, q);
	endtask

	task automatic rd(input logic [5:0] a, output logic [31:0] q);
		xfer(1'h1, a, 32'h00000000, q);
	endtask

	// Scripts are only handed over with every loop open matched by a close
	task automatic load(input logic [31:0] prog[$]);
		wr(6'h08, 32'h00000000);
		foreach (prog[i])
			wr(6'h0C, prog[i]);
	endtask
endmodule

// ### rcs_ms_tick.sv
// Millisecond timebase: one-cycle tick every CYCLES clocks, restartable.
// Assumes the single core clock and a synchronous active-low reset.
`timescale 1ns/10ps
module rcs_ms_tick
#(
	parameter int CYCLES = 250000
)
(
	input wire logic core_clk, // Core clock
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic restart, // Restart the period from zero
	output logic tick // One-cycle pulse per period
);
	localparam int CW = $clog2(CYCLES);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic tick;
	} rcs_tick_state_t;
	rcs_tick_state_t st_q;
	rcs_tick_state_t st_d;
	logic [CW:0] gap_q;

	if (CYCLES < 2)
		$error("CYCLES must be at least 2");

	always_comb
	begin
		st_d = st_q;
		st_d.tick = 1'h0;
		if (restart)
			st_d.cnt = '0;
		else if (st_q.cnt == CW'(CYCLES - 1))
		begin
			st_d.cnt = '0;
			st_d.tick = 1'h1;
		end
		else
			st_d.cnt = st_q.cnt + 1'h1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign tick = st_q.tick;

	// Cycles since the last restart; the cycle after a tick counts as one
	always_ff @(posedge core_clk)
	begin
		if (!reset_n || restart)
			gap_q <= '0;
		else if (st_q.tick)
			gap_q <= (CW + 1)'(1);
		else
			gap_q <= gap_q + 1'h1;
	end

	a_tick_period: assert property (@(posedge core_clk) disable iff (!reset_n)
		st_q.tick && !$past(restart) |-> gap_q == (CW + 1)'(CYCLES))
		else $error("tick period wrong");
endmodule

// ### rcs_pkg.sv
// Types of the ringing cadence sequencer: script opcodes, statement layout, modes.
// Assumes nothing of its surroundings.
package rcs_pkg;
	typedef enum logic [3:0] {
		RCS_OP_NAME,
		RCS_OP_ON,
		RCS_OP_OFF,
		RCS_OP_DELAY,
		RCS_OP_LOOP_OPEN,
		RCS_OP_REPEAT_CLOSE,
		RCS_OP_STOP,
		RCS_OP_SET,
		RCS_OP_INC,
		RCS_OP_DEC,
		RCS_OP_END
	} rcs_op_t;
	typedef struct packed {
		rcs_op_t op;
		logic [1:0] idx;
		logic [5:0] rsvd;
		logic [19:0] arg;
	} rcs_instr_t;
	typedef enum logic [1:0] {
		RCS_HOOK_STOP,
		RCS_HOOK_MUTE,
		RCS_HOOK_NONE
	} rcs_hook_act_t;
	typedef enum logic [1:0] {
		RCS_IDLE,
		RCS_RUN,
		RCS_WAIT
	} rcs_seq_state_t;
endpackage

// ### rcs_script_store.sv
// Script store: four fixed cadences plus one loadable script memory.
// Assumes the sequencer supplies write strobes on the same clock.
`timescale 1ns/10ps
module rcs_script_store
#(
	parameter int USER_WORDS = 64,
	parameter int PCW = 7
)
(
	input wire logic core_clk, // Core clock
	input wire logic wr_en, // Write one statement
	input wire logic [PCW-1:0] wr_addr, // Statement index written
	input wire logic [31:0] wr_data, // Statement written
	input wire logic [2:0] sel, // Cadence, 0 to 3 fixed, 4 loadable
	input wire logic [PCW-1:0] pc, // Statement index read
	output rcs_pkg::rcs_instr_t instr // Statement at pc
);
	import rcs_pkg::*;
	logic [31:0] mem [USER_WORDS];

	function automatic rcs_instr_t mk(rcs_op_t op, logic [19:0] arg);
		mk = '{op: op, idx: 2'h0, rsvd: 6'h00, arg: arg};
	endfunction

	function automatic rcs_instr_t fixed(logic [1:0] s, logic [PCW-1:0] p);
		fixed = mk(RCS_OP_END, 20'h00000);
		case (s)
		2'h0:
			if (p == PCW'(1))
				fixed = mk(RCS_OP_ON, 20'h00000);
		2'h1:
			case (p)
			PCW'(1): fixed = mk(RCS_OP_ON, 20'h00000);
			PCW'(2): fixed = mk(RCS_OP_DELAY, `RCS_BURST_MS);
			PCW'(3): fixed = mk(RCS_OP_OFF, 20'h00000);
			default: ;
			endcase
		2'h2:
			case (p)
			PCW'(1): fixed = mk(RCS_OP_LOOP_OPEN, 20'h00000);
			PCW'(2): fixed = mk(RCS_OP_ON, 20'h00000);
			PCW'(3): fixed = mk(RCS_OP_DELAY, `RCS_SINGLE_ON_MS);
			PCW'(4): fixed = mk(RCS_OP_OFF, 20'h00000);
			PCW'(5): fixed = mk(RCS_OP_DELAY, `RCS_SINGLE_OFF_MS);
			PCW'(6): fixed = mk(RCS_OP_REPEAT_CLOSE, 20'h00000);
			default: ;
			endcase
		default:
			case (p)
			PCW'(1): fixed = mk(RCS_OP_LOOP_OPEN, 20'h00000);
			PCW'(2): fixed = mk(RCS_OP_ON, 20'h00000);
			PCW'(3): fixed = mk(RCS_OP_DELAY, `RCS_DOUBLE_ON_MS);
			PCW'(4): fixed = mk(RCS_OP_OFF, 20'h00000);
			PCW'(5): fixed = mk(RCS_OP_DELAY, `RCS_DOUBLE_GAP_MS);
			PCW'(6): fixed = mk(RCS_OP_ON, 20'h00000);
			PCW'(7): fixed = mk(RCS_OP_DELAY, `RCS_DOUBLE_ON_MS);
			PCW'(8): fixed = mk(RCS_OP_OFF, 20'h00000);
			PCW'(9): fixed = mk(RCS_OP_DELAY, `RCS_DOUBLE_OFF_MS);
			PCW'(10): fixed = mk(RCS_OP_REPEAT_CLOSE, 20'h00000);
			default: ;
			endcase
		endcase
	endfunction

	always_ff @(posedge core_clk)
	begin
		if (wr_en && (wr_addr < PCW'(USER_WORDS)))
			mem[wr_addr[$clog2(USER_WORDS)-1:0]] <= wr_data;
	end

	// Past the end of memory the script reads as finished
	always_comb
	begin
		if (sel[2] == 1'h0)
			instr = fixed(sel[1:0], pc);
		else if ((sel == 3'h4) && (pc < PCW'(USER_WORDS)))
			instr = rcs_instr_t'(mem[pc[$clog2(USER_WORDS)-1:0]]);
		else
			instr = mk(RCS_OP_END, 20'h00000);
	end
endmodule

// ### tb.sv
// Self-checking bench of the ringing cadence sequencer.
// Assumes a 4 ns core clock and a 10-cycle millisecond tick.
`timescale 1ns/10ps
module tb;
	import rcs_pkg::*;
	logic core_clk;
	logic reset_n;
	logic offhook_pin;
	logic [5:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic ring_on;
	logic ac_mute;
	logic cadence_active;
	logic [15:0] ring_freq;
	logic [15:0] ring_level;
	logic [15:0] ring_offset;
	rcs_hook_act_t hook_action;
	int n_mismatch;
	int cmp_count;
	int cyc = 0;
	int n;
	logic [31:0] q;
	logic [31:0] prog[$];

	initial core_clk = 1'h0;
	always #2 core_clk = ~core_clk;

	rcs_host_model u_host (.core_clk(core_clk), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	rcs_cadence_sequencer #(.TICK_CYCLES(10)) u_dut (.core_clk(core_clk), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .offhook_pin(offhook_pin), .ring_on(ring_on),
		.ac_mute(ac_mute), .cadence_active(cadence_active), .ring_freq(ring_freq),
		.ring_level(ring_level), .ring_offset(ring_offset), .hook_action(hook_action));

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [31:0] st(input rcs_op_t op, input logic [1:0] ix,
		input logic [19:0] a);
		return {op, ix, 6'h00, a};
	endfunction

	task automatic go(input logic [1:0] act, input logic [2:0] sel);
		u_host.wr(6'h00, {25'h0000000, act, sel, 2'h1});
	endtask

	// Counts cycles until ring_on reaches v; returns right after a rising edge
	task automatic edge_to(input logic v, input int lim, output int cnt);
		cnt = 0;
		@(negedge core_clk);
		while (ring_on !== v && cnt < lim)
		begin
			@(negedge core_clk);
			cnt++;
		end
		@(posedge core_clk);
	endtask

	task automatic until_idle(input int lim);
		int k;
		k = 0;
		@(negedge core_clk);
		while (cadence_active !== 1'h0 && k < lim)
		begin
			@(negedge core_clk);
			k++;
		end
		@(posedge core_clk);
	endtask

	task automatic t_settings;
		prog = {st(RCS_OP_ON, 2'h0, 20'h00000), st(RCS_OP_SET, 2'h0, 20'h00016),
			st(RCS_OP_INC, 2'h0, 20'h00002), st(RCS_OP_SET, 2'h1, 20'h00064),
			st(RCS_OP_DEC, 2'h1, 20'h0001E), st(RCS_OP_SET, 2'h2, 20'h00005),
			st(RCS_OP_INC, 2'h2, 20'h00003), st(RCS_OP_SET, 2'h3, 20'h00007),
			st(RCS_OP_ON, 2'h0, 20'h00000), st(RCS_OP_DELAY, 2'h0, 20'h00005),
			st(RCS_OP_OFF, 2'h0, 20'h00000), st(RCS_OP_END, 2'h0, 20'h00000)};
		u_host.load(prog);
		go(2'h0, 3'h4);
		edge_to(1'h1, 100, n);
		chk("name_skipped", n >= 4, 1);
		edge_to(1'h0, 100, n);
		chk("delay_5ms", n >= 50 && n <= 56, 1);
		until_idle(50);
		@(negedge core_clk);
		chk("script_end", cadence_active, 0);
		chk("freq", ring_freq, 16'h0018);
		chk("level", ring_level, 16'h0046);
		chk("offset", ring_offset, 16'h0008);
		@(posedge core_clk);
		u_host.rd(6'h1C, q);
		chk("shape", q[15:0], 16'h0007);
	endtask

	task automatic t_loops;
		u_host.wr(6'h10, 32'h00000000);
		prog = {st(RCS_OP_NAME, 2'h0, 20'h00000)};
		repeat (10) prog.push_back(st(RCS_OP_LOOP_OPEN, 2'h0, 20'h00002));
		prog.push_back(st(RCS_OP_INC, 2'h0, 20'h00001));
		repeat (10) prog.push_back(st(RCS_OP_REPEAT_CLOSE, 2'h0, 20'h00000));
		prog.push_back(st(RCS_OP_LOOP_OPEN, 2'h0, 20'h00003));
		prog.push_back(st(RCS_OP_INC, 2'h0, 20'h00001));
		prog.push_back(st(RCS_OP_REPEAT_CLOSE, 2'h0, 20'h00000));
		prog.push_back(st(RCS_OP_END, 2'h0, 20'h00000));
		u_host.load(prog);
		go(2'h0, 3'h4);
		until_idle(20000);
		chk("nested_count", ring_freq, 16'h0403);
		u_host.rd(6'h04, q);
		chk("nest_ok", q[4], 1'h0);
		prog = {st(RCS_OP_NAME, 2'h0, 20'h00000)};
		repeat (11) prog.push_back(st(RCS_OP_LOOP_OPEN, 2'h0, 20'h00001));
		repeat (11) prog.push_back(st(RCS_OP_REPEAT_CLOSE, 2'h0, 20'h00000));
		u_host.load(prog);
		go(2'h0, 3'h4);
		until_idle(200);
		u_host.rd(6'h04, q);
		chk("nest_over", q[4], 1'h1);
	endtask

	task automatic t_end;
		prog = {st(RCS_OP_NAME, 2'h0, 20'h00000), st(RCS_OP_ON, 2'h0, 20'h00000),
			st(RCS_OP_STOP, 2'h0, 20'h00000), st(RCS_OP_OFF, 2'h0, 20'h00000)};
		u_host.load(prog);
		go(2'h0, 3'h4);
		until_idle(50);
		repeat (100) @(posedge core_clk);
		@(negedge core_clk);
		chk("stop_stmt", cadence_active, 0);
		chk("ring_kept", ring_on, 1);
		@(posedge core_clk);
		u_host.wr(6'h00, 32'h00000040);
		offhook_pin <= 1'h1;
		repeat (10) @(posedge core_clk);
		@(negedge core_clk);
		chk("hook_ignored", {ring_on, ac_mute}, 2'h2);
		@(posedge core_clk);
		offhook_pin <= 1'h0;
		repeat (10) @(posedge core_clk);
		u_host.wr(6'h00, 32'h00000002);
		@(negedge core_clk);
		chk("manual_stop", ring_on, 0);
		@(posedge core_clk);
	endtask

	task automatic t_mute;
		u_host.wr(6'h10, 32'h00000000);
		prog = {st(RCS_OP_NAME, 2'h0, 20'h00000), st(RCS_OP_LOOP_OPEN, 2'h0, 20'h00000),
			st(RCS_OP_INC, 2'h0, 20'h00001), st(RCS_OP_DELAY, 2'h0, 20'h00002),
			st(RCS_OP_REPEAT_CLOSE, 2'h0, 20'h00000)};
		u_host.load(prog);
		go(2'h1, 3'h4);
		repeat (100) @(posedge core_clk);
		offhook_pin <= 1'h1;
		repeat (10) @(posedge core_clk);
		@(negedge core_clk);
		chk("hook_action", hook_action, RCS_HOOK_MUTE);
		chk("muted", ac_mute, 1);
		chk("runs_on", cadence_active, 1);
		q = ring_freq;
		repeat (200) @(posedge core_clk);
		@(negedge core_clk);
		chk("endless", ring_freq > q[15:0] && ring_freq > 16'h000A, 1);
		@(posedge core_clk);
		offhook_pin <= 1'h0;
		repeat (10) @(posedge core_clk);
		@(negedge core_clk);
		chk("unmuted", ac_mute, 0);
		@(posedge core_clk);
		u_host.wr(6'h00, 32'h00000002);
		@(negedge core_clk);
		chk("stopped", cadence_active, 0);
		@(posedge core_clk);
	endtask

	task automatic t_builtin;
		for (int s = 0; s < 4; s++)
		begin
			go(2'h0, s[2:0]);
			repeat (30) @(posedge core_clk);
			@(negedge core_clk);
			chk("fixed_on", ring_on, 1);
			@(posedge core_clk);
			u_host.wr(6'h00, 32'h00000002);
			@(negedge core_clk);
			chk("fixed_off", ring_on, 0);
			@(posedge core_clk);
		end
	endtask

	task automatic t_cadences;
		go(2'h0, 3'h2);
		edge_to(1'h1, 50, n);
		edge_to(1'h0, 21000, n);
		chk("single_on", n >= 20000 && n <= 20005, 1);
		u_host.wr(6'h00, 32'h00000002);
		go(2'h0, 3'h3);
		edge_to(1'h1, 50, n);
		edge_to(1'h0, 8000, n);
		chk("double_on", n >= 7000 && n <= 7005, 1);
		edge_to(1'h1, 7000, n);
		chk("double_gap", n >= 6000 && n <= 6005, 1);
		repeat (100) @(posedge core_clk);
		offhook_pin <= 1'h1;
		edge_to(1'h0, 12, n);
		@(negedge core_clk);
		chk("hook_stop", ring_on, 0);
		chk("hook_halt", cadence_active, 0);
		@(posedge core_clk);
		offhook_pin <= 1'h0;
		repeat (200) @(posedge core_clk);
		@(negedge core_clk);
		chk("no_restart", ring_on, 0);
		@(posedge core_clk);
	endtask

	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 80000)
		begin
			n_mismatch++;
			close_out();
		end
	end

	initial
	begin
		reset_n = 1'h0;
		offhook_pin = 1'h0;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (6) @(posedge core_clk);
		reset_n <= 1'h1;
		@(posedge core_clk);
		t_settings();
		t_loops();
		t_end();
		t_mute();
		t_builtin();
		t_cadences();
		close_out();
	end
endmodule
